// file: pmx_cfg.svh
// Register indices, subregister codes, field positions and reset values.
`ifndef PMX_CFG_SVH
`define PMX_CFG_SVH

`define PMX_IDX_PA_ADDR 12'hfd0
`define PMX_IDX_PA_CTL 12'hfd1
`define PMX_IDX_PB_ADDR 12'hfd4
`define PMX_IDX_PB_CTL 12'hfd5
`define PMX_IDX_PC_ADDR 12'hfd8
`define PMX_IDX_PC_CTL 12'hfd9
`define PMX_IDX_PD_ADDR 12'hfdc
`define PMX_IDX_PD_CTL 12'hfdd
`define PMX_IDX_INT_STAT 12'hfe0
`define PMX_IDX_INT_MASK 12'hfe1
`define PMX_IDX_EDGE_SEL 12'hfe2

`define PMX_SUB_DIR 8'h01
`define PMX_SUB_ALT_EN 8'h02
`define PMX_SUB_FSS1 8'h07
`define PMX_SUB_FSS2 8'h08

`define PMX_BIT_CONV_IN4 0
`define PMX_BIT_CONV_IN5 1
`define PMX_BIT_CONV_IN6 2
`define PMX_BIT_COMP_OUT 3
`define PMX_BIT_PD_RESET 0

`define PMX_RST_ADDR 8'h00
`define PMX_RST_DIR 8'hff
`define PMX_RST_ALT_EN 8'h00
`define PMX_RST_ALT_EN_PD 8'h01
`define PMX_RST_FSS 8'h00
`define PMX_RST_EDGE_SEL 8'hff
`define PMX_RST_MASK 16'h0000
`define PMX_PD_IMPL 8'h01
`define PMX_FULL_IMPL 8'hff
`define PMX_PIN_IDLE 17'h10000

`endif

// file: pmx_pkg.sv
// Shared types of the port function select block.
package pmx_pkg;
    typedef logic [7:0] pmx_byte_t;
    typedef enum {PMX_PA, PMX_PB, PMX_PC, PMX_PD} pmx_port_t;
endpackage

// file: pmx_pin_if.sv
// Synchronised pin levels and edge pulses between the pin stage and the top.
`timescale 1ns/1ns
interface pmx_pin_if #(parameter int W = 17);
    logic [W-1:0] level;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface

// file: pmx_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses.
`timescale 1ns/1ns
module pmx_pin_sync #(
    parameter int W = 17,
    parameter logic [W-1:0] IDLE = '0
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_raw,
    pmx_pin_if.src pins
);
    if (W < 1) begin : g_bad_width
        $error("pmx_pin_sync needs at least one pin");
    end

    for (genvar b = 0; b < W; b++) begin : g_bit
        logic s1_r;
        logic s2_r;
        logic s3_r;
        logic level_r;
        logic rise_r;
        logic fall_r;
        logic agree;

        assign agree = (s2_r == s3_r);

        // Stages start at the pin's idle level so no false edge follows reset.
        always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
                s1_r <= IDLE[b];
                s2_r <= IDLE[b];
                s3_r <= IDLE[b];
            end else begin
                s1_r <= i_raw[b];
                s2_r <= s1_r;
                s3_r <= s2_r;
            end
        end

        // A change counts only once the second and third stage agree.
        always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
                level_r <= IDLE[b];
                rise_r <= 1'b0;
                fall_r <= 1'b0;
            end else begin
                rise_r <= agree & s3_r & ~level_r;
                fall_r <= agree & ~s3_r & level_r;
                if (agree) begin
                    level_r <= s3_r;
                end
            end
        end

        assign pins.level[b] = level_r;
        assign pins.rise[b] = rise_r;
        assign pins.fall[b] = fall_r;
    end
endmodule

// file: pmx_port_mux.sv
// Port function select mux with APB register access and pin edge interrupts.
//
// How it works
// - First port and fourth-port pin have no function set registers.
// - On those pins the alternate enable alone routes the single function.
// - Second set register exists on second and third ports, no effect.
// - Third-port analog function needs enable and first set bit together.
// - Third port: pins 0-2 analog when set, pin 3 comparator when clear.
// - Fourth-port pin defaults to external reset input role.
// - First-port pins raise interrupts on a selected rising or falling edge.
// - Third-port pins raise interrupts on every edge.
// - Active alternate function overrides the pin direction setting.
// - First set register reached as subregister 07h via the port address.
`timescale 1ns/1ns
`include "pmx_cfg.svh"
module pmx_port_mux #(
    parameter int PADDR_W = 16
) (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [PADDR_W-1:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire pmx_pkg::pmx_byte_t I_PA_PIN,
    input wire pmx_pkg::pmx_byte_t I_PC_PIN,
    input wire logic I_PD_PIN,
    input wire pmx_pkg::pmx_byte_t I_PA_DOUT,
    input wire pmx_pkg::pmx_byte_t I_PA_ALT_DOUT,
    input wire pmx_pkg::pmx_byte_t I_PC_DOUT,
    input wire logic I_COMPARATOR_RESULT,
    output pmx_pkg::pmx_byte_t O_PA_OUT,
    output pmx_pkg::pmx_byte_t O_PA_OE_N,
    output pmx_pkg::pmx_byte_t O_PC_OUT,
    output pmx_pkg::pmx_byte_t O_PC_OE_N,
    output pmx_pkg::pmx_byte_t O_PA_ALT_EN,
    output logic O_CONV_IN4_COMP_POS_EN,
    output logic O_CONV_IN5_COMP_NEG_EN,
    output logic O_CONV_ANALOG_IN6_EN,
    output logic O_COMPARATOR_RESULT_OUT_EN,
    output logic O_PD_RESET_EN,
    output logic O_EXT_RESET_N,
    output logic O_IRQ
);
    import pmx_pkg::*;

    localparam int NP = 4;
    localparam logic [11:0] ADDR_IDX [NP] = '{`PMX_IDX_PA_ADDR,
        `PMX_IDX_PB_ADDR, `PMX_IDX_PC_ADDR, `PMX_IDX_PD_ADDR};
    localparam logic [11:0] CTL_IDX [NP] = '{`PMX_IDX_PA_CTL,
        `PMX_IDX_PB_CTL, `PMX_IDX_PC_CTL, `PMX_IDX_PD_CTL};

    if (PADDR_W < 15) begin : g_bad_addr
        $error("pmx_port_mux needs at least 15 address bits");
    end

    pmx_byte_t addr_r [NP];
    pmx_byte_t dir_r [NP];
    pmx_byte_t alt_en_r [NP];
    pmx_byte_t fss1_r [NP];
    pmx_byte_t fss2_r [NP];
    pmx_byte_t edge_sel_r;
    logic [15:0] stat_r;
    logic [15:0] stat_nxt;
    logic [15:0] mask_r;
    logic [15:0] events;
    logic ready_r;
    logic [11:0] idx;
    logic aligned;
    logic port_hit;
    logic is_ctl;
    logic [1:0] port_sel;
    logic hit;
    logic [31:0] rdata_nxt;
    logic wr;
    logic wr_addr;
    logic wr_sub;
    pmx_byte_t pc_sel;
    pmx_byte_t pc_out_nxt;
    pmx_byte_t pc_oe_n_nxt;
    logic comp_on;

    pmx_pin_if #(.W(17)) pins ();

    pmx_pin_sync #(.W(17), .IDLE(`PMX_PIN_IDLE)) u_sync (
        .i_clk(I_CLK),
        .i_rst_n(I_RST_N),
        .i_raw({I_PD_PIN, I_PC_PIN, I_PA_PIN}),
        .pins(pins)
    );

    function automatic logic has_fss(input logic [1:0] p);
        return (p == 2'(PMX_PB)) || (p == 2'(PMX_PC));
    endfunction

    function automatic pmx_byte_t impl_mask(input logic [1:0] p);
        return (p == 2'(PMX_PD)) ? `PMX_PD_IMPL : `PMX_FULL_IMPL;
    endfunction

    function automatic pmx_byte_t sub_read(input logic [1:0] p);
        pmx_byte_t v;
        v = '0;
        if (addr_r[p] == `PMX_SUB_DIR) begin
            v = dir_r[p];
        end else if (addr_r[p] == `PMX_SUB_ALT_EN) begin
            v = alt_en_r[p];
        end else if (addr_r[p] == `PMX_SUB_FSS1 && has_fss(p)) begin
            v = fss1_r[p];
        end else if (addr_r[p] == `PMX_SUB_FSS2 && has_fss(p)) begin
            v = fss2_r[p];
        end
        return v;
    endfunction

    assign idx = I_PADDR[13:2];
    assign aligned = (I_PADDR[1:0] == 2'h0) &&
        (I_PADDR[PADDR_W-1:14] == '0);
    assign wr = I_PSEL & I_PENABLE & I_PWRITE & ready_r;
    assign wr_addr = wr & hit & port_hit & ~is_ctl;
    assign wr_sub = wr & hit & port_hit & is_ctl;

    always_comb begin
        port_hit = 1'b0;
        is_ctl = 1'b0;
        port_sel = 2'h0;
        for (int p = 0; p < NP; p++) begin
            if (idx == ADDR_IDX[p]) begin
                port_hit = 1'b1;
                port_sel = 2'(p);
            end else if (idx == CTL_IDX[p]) begin
                port_hit = 1'b1;
                is_ctl = 1'b1;
                port_sel = 2'(p);
            end
        end
    end

    always_comb begin
        rdata_nxt = '0;
        hit = 1'b1;
        if (!aligned) begin
            hit = 1'b0;
        end else if (idx == `PMX_IDX_INT_STAT) begin
            rdata_nxt = {16'h0000, stat_r};
        end else if (idx == `PMX_IDX_INT_MASK) begin
            rdata_nxt = {16'h0000, mask_r};
        end else if (idx == `PMX_IDX_EDGE_SEL) begin
            rdata_nxt = {24'h000000, edge_sel_r};
        end else if (port_hit && is_ctl) begin
            rdata_nxt = {24'h000000, sub_read(port_sel)};
        end else if (port_hit) begin
            rdata_nxt = {24'h000000, addr_r[port_sel]};
        end else begin
            hit = 1'b0;
        end
    end

    // Every transfer completes without wait states; read data are caught at setup.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            ready_r <= 1'b0;
            O_PRDATA <= '0;
            O_PSLVERR <= 1'b0;
        end else begin
            ready_r <= I_PSEL & ~I_PENABLE;
            if (I_PSEL && !I_PENABLE) begin
                O_PRDATA <= I_PWRITE ? 32'h00000000 : rdata_nxt;
                O_PSLVERR <= ~hit;
            end
        end
    end
    assign O_PREADY = ready_r;

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            for (int p = 0; p < NP; p++) begin
                addr_r[p] <= `PMX_RST_ADDR;
            end
        end else if (wr_addr) begin
            addr_r[port_sel] <= I_PWDATA[7:0];
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            for (int p = 0; p < NP; p++) begin
                dir_r[p] <= `PMX_RST_DIR & impl_mask(2'(p));
                alt_en_r[p] <= (p == int'(PMX_PD)) ? `PMX_RST_ALT_EN_PD
                    : `PMX_RST_ALT_EN;
                fss1_r[p] <= `PMX_RST_FSS;
                fss2_r[p] <= `PMX_RST_FSS;
            end
        end else if (wr_sub) begin
            if (addr_r[port_sel] == `PMX_SUB_DIR) begin
                dir_r[port_sel] <= I_PWDATA[7:0] & impl_mask(port_sel);
            end else if (addr_r[port_sel] == `PMX_SUB_ALT_EN) begin
                alt_en_r[port_sel] <= I_PWDATA[7:0] & impl_mask(port_sel);
            end else if (addr_r[port_sel] == `PMX_SUB_FSS1 &&
                has_fss(port_sel)) begin
                fss1_r[port_sel] <= I_PWDATA[7:0];
            end else if (addr_r[port_sel] == `PMX_SUB_FSS2 &&
                has_fss(port_sel)) begin
                fss2_r[port_sel] <= I_PWDATA[7:0];
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            mask_r <= `PMX_RST_MASK;
            edge_sel_r <= `PMX_RST_EDGE_SEL;
        end else if (wr && hit && idx == `PMX_IDX_INT_MASK) begin
            mask_r <= I_PWDATA[15:0];
        end else if (wr && hit && idx == `PMX_IDX_EDGE_SEL) begin
            edge_sel_r <= I_PWDATA[7:0];
        end
    end

    // Edge select bit one means rising edge on that first-port pin.
    assign events[7:0] = (pins.rise[7:0] & edge_sel_r) |
        (pins.fall[7:0] & ~edge_sel_r);
    assign events[15:8] = pins.rise[15:8] | pins.fall[15:8];

    // A new event wins over a write-one clear in the same cycle.
    always_comb begin
        stat_nxt = stat_r;
        if (wr && hit && idx == `PMX_IDX_INT_STAT) begin
            stat_nxt = stat_r & ~I_PWDATA[15:0];
        end
        stat_nxt = stat_nxt | events;
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            stat_r <= '0;
            O_IRQ <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            O_IRQ <= |(stat_r & mask_r);
        end
    end

    assign pc_sel = alt_en_r[PMX_PC] & fss1_r[PMX_PC];
    assign comp_on = alt_en_r[PMX_PC][`PMX_BIT_COMP_OUT] &
        ~fss1_r[PMX_PC][`PMX_BIT_COMP_OUT];

    always_comb begin
        pc_out_nxt = I_PC_DOUT;
        pc_oe_n_nxt = dir_r[PMX_PC];
        pc_oe_n_nxt[2:0] = dir_r[PMX_PC][2:0] | pc_sel[2:0];
        if (comp_on) begin
            pc_out_nxt[`PMX_BIT_COMP_OUT] = I_COMPARATOR_RESULT;
            pc_oe_n_nxt[`PMX_BIT_COMP_OUT] = 1'b0;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_PA_OUT <= '0;
            O_PA_OE_N <= `PMX_RST_DIR;
            O_PA_ALT_EN <= `PMX_RST_ALT_EN;
        end else begin
            O_PA_OUT <= (alt_en_r[PMX_PA] & I_PA_ALT_DOUT) |
                (~alt_en_r[PMX_PA] & I_PA_DOUT);
            O_PA_OE_N <= ~alt_en_r[PMX_PA] & dir_r[PMX_PA];
            O_PA_ALT_EN <= alt_en_r[PMX_PA];
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_PC_OUT <= '0;
            O_PC_OE_N <= `PMX_RST_DIR;
            O_CONV_IN4_COMP_POS_EN <= 1'b0;
            O_CONV_IN5_COMP_NEG_EN <= 1'b0;
            O_CONV_ANALOG_IN6_EN <= 1'b0;
            O_COMPARATOR_RESULT_OUT_EN <= 1'b0;
        end else begin
            O_PC_OUT <= pc_out_nxt;
            O_PC_OE_N <= pc_oe_n_nxt;
            O_CONV_IN4_COMP_POS_EN <= pc_sel[`PMX_BIT_CONV_IN4];
            O_CONV_IN5_COMP_NEG_EN <= pc_sel[`PMX_BIT_CONV_IN5];
            O_CONV_ANALOG_IN6_EN <= pc_sel[`PMX_BIT_CONV_IN6];
            O_COMPARATOR_RESULT_OUT_EN <= comp_on;
        end
    end

    // The reset role needs only its enable bit; the pin is input only.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_PD_RESET_EN <= 1'b1;
            O_EXT_RESET_N <= 1'b1;
        end else begin
            O_PD_RESET_EN <= alt_en_r[PMX_PD][`PMX_BIT_PD_RESET];
            O_EXT_RESET_N <= ~alt_en_r[PMX_PD][`PMX_BIT_PD_RESET] |
                pins.level[16];
        end
    end

    a_no_fss_regs: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        fss1_r[PMX_PA] == 8'h00 && fss2_r[PMX_PA] == 8'h00 &&
        fss1_r[PMX_PD] == 8'h00 && fss2_r[PMX_PD] == 8'h00)
        else $error("function set register held on a single-use port");

    a_pa_alt_drive: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        alt_en_r[PMX_PA] != 8'h00 |=>
        (O_PA_OE_N & $past(alt_en_r[PMX_PA])) == 8'h00 &&
        O_PA_ALT_EN == $past(alt_en_r[PMX_PA]))
        else $error("first port alternate pin not driven");

    a_fss2_no_effect: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        $changed(fss2_r[PMX_PC]) && $stable(fss1_r[PMX_PC]) &&
        $stable(alt_en_r[PMX_PC]) && $stable(dir_r[PMX_PC]) &&
        $stable(I_PC_DOUT) && $stable(I_COMPARATOR_RESULT) |=>
        $stable(O_PC_OE_N) && $stable(O_PC_OUT))
        else $error("second set register changed a pin");

    a_pc_needs_en: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        alt_en_r[PMX_PC][2:0] == 3'h0 |=> !O_CONV_IN4_COMP_POS_EN &&
        !O_CONV_IN5_COMP_NEG_EN && !O_CONV_ANALOG_IN6_EN)
        else $error("analog route without its enable");

    a_pc_analog_in: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        alt_en_r[PMX_PC][1] && fss1_r[PMX_PC][1] |=>
        O_CONV_IN5_COMP_NEG_EN && O_PC_OE_N[1])
        else $error("negative input pin not routed");

    a_pc_comp_out: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        alt_en_r[PMX_PC][3] && !fss1_r[PMX_PC][3] |=>
        O_COMPARATOR_RESULT_OUT_EN && !O_PC_OE_N[3] &&
        O_PC_OUT[3] == $past(I_COMPARATOR_RESULT))
        else $error("comparator output not on pin");

    a_pd_reset_role: assert property (
        @(posedge I_CLK) $rose(I_RST_N) |-> ##1 O_PD_RESET_EN [*2])
        else $error("reset role not default after reset");

    a_sel_edge_irq: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        pins.rise[0] && edge_sel_r[0] ##1 mask_r[0] |=> O_IRQ)
        else $error("selected rising edge raised no interrupt");

    a_any_edge_irq: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        pins.fall[8] || pins.rise[8] |=> stat_r[8])
        else $error("third port edge not recorded");

    a_fss1_write: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        wr_sub && port_sel == 2'(PMX_PC) &&
        addr_r[PMX_PC] == `PMX_SUB_FSS1 |=>
        fss1_r[PMX_PC] == $past(I_PWDATA[7:0]))
        else $error("subregister 07h write lost");

    a_upper_plain: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        1'b1 |=> O_PC_OE_N[7:4] == $past(dir_r[PMX_PC][7:4]) &&
        O_PC_OUT[7:4] == $past(I_PC_DOUT[7:4]))
        else $error("upper third port pin not plain");
endmodule

// file: pmx_board.sv
// Board model that resolves the port pins from design drive and board level.
`timescale 1ns/1ns
module pmx_board (
    input wire pmx_pkg::pmx_byte_t i_pa_out,
    input wire pmx_pkg::pmx_byte_t i_pa_oe_n,
    input wire pmx_pkg::pmx_byte_t i_pc_out,
    input wire pmx_pkg::pmx_byte_t i_pc_oe_n,
    output pmx_pkg::pmx_byte_t o_pa_pin,
    output pmx_pkg::pmx_byte_t o_pc_pin,
    output logic o_pd_pin
);
    import pmx_pkg::*;
    // Levels the board applies where the design does not drive.
    pmx_byte_t pa_ext = 8'h00;
    pmx_byte_t pc_ext = 8'h00;
    logic pd_ext = 1'b1;
    // A driving design output wins over the board level.
    assign o_pa_pin = (~i_pa_oe_n & i_pa_out) | (i_pa_oe_n & pa_ext);
    assign o_pc_pin = (~i_pc_oe_n & i_pc_out) | (i_pc_oe_n & pc_ext);
    // The reset pin is only ever driven from the board.
    assign o_pd_pin = pd_ext;
endmodule

// file: pmx_tb.sv
// Self-checking testbench of the port function select mux.
`timescale 1ns/1ns
`include "pmx_cfg.svh"
module testbench;
    import pmx_pkg::*;
    logic I_CLK = 1'b0;
    logic I_RST_N = 1'b0;
    logic I_PSEL = 1'b0;
    logic I_PENABLE = 1'b0;
    logic I_PWRITE = 1'b0;
    logic [15:0] I_PADDR = 16'h0000;
    logic [31:0] I_PWDATA = 32'h0;
    logic [31:0] O_PRDATA;
    logic O_PREADY, O_PSLVERR;
    pmx_byte_t pa_pin, pc_pin, pa_out, pa_oe_n, pc_out, pc_oe_n, pa_alt;
    pmx_byte_t I_PA_DOUT = 8'h00;
    pmx_byte_t I_PA_ALT_DOUT = 8'h5a;
    pmx_byte_t I_PC_DOUT = 8'hc3;
    logic I_COMPARATOR_RESULT = 1'b1;
    logic pd_pin, in4, in5, in6, cmp_en, pd_rst_en, ext_rst_n, irq;
    logic [31:0] rdat;
    logic rerr;
    int failures = 0;
    int compares = 0;

    always #50 I_CLK = ~I_CLK;

    pmx_port_mux uut (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL),
        .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
        .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
        .O_PSLVERR(O_PSLVERR), .I_PA_PIN(pa_pin), .I_PC_PIN(pc_pin),
        .I_PD_PIN(pd_pin), .I_PA_DOUT(I_PA_DOUT),
        .I_PA_ALT_DOUT(I_PA_ALT_DOUT), .I_PC_DOUT(I_PC_DOUT),
        .I_COMPARATOR_RESULT(I_COMPARATOR_RESULT), .O_PA_OUT(pa_out),
        .O_PA_OE_N(pa_oe_n), .O_PC_OUT(pc_out), .O_PC_OE_N(pc_oe_n),
        .O_PA_ALT_EN(pa_alt), .O_CONV_IN4_COMP_POS_EN(in4),
        .O_CONV_IN5_COMP_NEG_EN(in5), .O_CONV_ANALOG_IN6_EN(in6),
        .O_COMPARATOR_RESULT_OUT_EN(cmp_en), .O_PD_RESET_EN(pd_rst_en),
        .O_EXT_RESET_N(ext_rst_n), .O_IRQ(irq));

    pmx_board board (.i_pa_out(pa_out), .i_pa_oe_n(pa_oe_n),
        .i_pc_out(pc_out), .i_pc_oe_n(pc_oe_n), .o_pa_pin(pa_pin),
        .o_pc_pin(pc_pin), .o_pd_pin(pd_pin));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [15:0] ba(input logic [11:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    // One APB transfer; the access phase is held until pready is sampled.
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
        @(posedge I_CLK);
        I_PSEL <= 1'b1;
        I_PENABLE <= 1'b0;
        I_PWRITE <= w;
        I_PADDR <= a;
        I_PWDATA <= d;
        @(posedge I_CLK);
        I_PENABLE <= 1'b1;
        do begin
            @(posedge I_CLK);
        end while (O_PREADY !== 1'b1);
        rdat = O_PRDATA;
        rerr = O_PSLVERR;
        I_PSEL <= 1'b0;
        I_PENABLE <= 1'b0;
    endtask

    task automatic rd(input string what, input logic [11:0] idx,
                      input logic [31:0] exp);
        apb(1'b0, ba(idx), 32'h0);
        chk(what, rdat, exp);
    endtask

    // Subregister write through a port's address register.
    task automatic sw(input logic [11:0] base, input logic [7:0] s,
                      input logic [7:0] v);
        apb(1'b1, ba(base), {24'h0, s});
        apb(1'b1, ba(12'(base + 12'h001)), {24'h0, v});
    endtask

    task automatic sr(input string what, input logic [11:0] base,
                      input logic [7:0] s, input logic [7:0] exp);
        apb(1'b1, ba(base), {24'h0, s});
        rd(what, 12'(base + 12'h001), {24'h0, exp});
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge I_CLK);
    endtask

    initial begin
        wt(16);
        I_RST_N <= 1'b1;
        wt(2);
        chk("ext_rst_n early", ext_rst_n, 1);
        wt(4);
        chk("pd_rst_en", pd_rst_en, 1);
        chk("ext_rst_n", ext_rst_n, 1);
        rd("pa_addr", `PMX_IDX_PA_ADDR, 0);
        sr("pd_alt", `PMX_IDX_PD_ADDR, `PMX_SUB_ALT_EN, 8'h01);
        rd("edge_sel", `PMX_IDX_EDGE_SEL, 32'hff);
        board.pd_ext <= 1'b0;
        wt(8);
        chk("ext_rst_n low", ext_rst_n, 0);
        sw(`PMX_IDX_PD_ADDR, `PMX_SUB_ALT_EN, 8'h00);
        wt(3);
        chk("pd_rst_en off", pd_rst_en, 0);
        chk("ext_rst_n off", ext_rst_n, 1);
        board.pd_ext <= 1'b1;
        sw(`PMX_IDX_PA_ADDR, `PMX_SUB_FSS1, 8'hff);
        sr("pa_fss1", `PMX_IDX_PA_ADDR, `PMX_SUB_FSS1, 8'h00);
        sw(`PMX_IDX_PD_ADDR, `PMX_SUB_FSS1, 8'hff);
        sr("pd_fss1", `PMX_IDX_PD_ADDR, `PMX_SUB_FSS1, 8'h00);
        sw(`PMX_IDX_PC_ADDR, `PMX_SUB_FSS1, 8'ha5);
        sr("pc_fss1", `PMX_IDX_PC_ADDR, `PMX_SUB_FSS1, 8'ha5);
        sw(`PMX_IDX_PC_ADDR, `PMX_SUB_FSS2, 8'hff);
        sr("pc_fss2", `PMX_IDX_PC_ADDR, `PMX_SUB_FSS2, 8'hff);
        sw(`PMX_IDX_PB_ADDR, `PMX_SUB_FSS2, 8'h3c);
        sr("pb_fss2", `PMX_IDX_PB_ADDR, `PMX_SUB_FSS2, 8'h3c);
        wt(3);
        chk("no alt", {in4, in5, in6, cmp_en}, 0);
        sw(`PMX_IDX_PC_ADDR, `PMX_SUB_ALT_EN, 8'hff);
        wt(3);
        chk("pc route a5", {in4, in5, in6, cmp_en}, 4'hb);
        chk("pc oe a5", pc_oe_n, 8'hf7);
        chk("comp out", pc_out[3], 1);
        sw(`PMX_IDX_PC_ADDR, `PMX_SUB_FSS1, 8'h5a);
        sw(`PMX_IDX_PC_ADDR, `PMX_SUB_DIR, 8'h00);
        wt(3);
        chk("pc route 5a", {in4, in5, in6, cmp_en}, 4'h4);
        chk("pc oe 5a", pc_oe_n, 8'h02);
        chk("pc plain out", pc_out[7:4], 4'hc);
        sw(`PMX_IDX_PC_ADDR, `PMX_SUB_DIR, 8'hff);
        sw(`PMX_IDX_PC_ADDR, `PMX_SUB_ALT_EN, 8'h00);
        sw(`PMX_IDX_PA_ADDR, `PMX_SUB_ALT_EN, 8'h0f);
        wt(3);
        chk("pa alt", pa_alt, 8'h0f);
        chk("pa oe", pa_oe_n, 8'hf0);
        chk("pa out", pa_out[3:0], 4'ha);
        sw(`PMX_IDX_PA_ADDR, `PMX_SUB_ALT_EN, 8'h00);
        apb(1'b1, ba(`PMX_IDX_EDGE_SEL), 32'hfd);
        apb(1'b1, ba(`PMX_IDX_INT_MASK), 32'hffff);
        apb(1'b1, ba(`PMX_IDX_INT_STAT), 32'hffff);
        wt(4);
        board.pa_ext <= 8'h03;
        wt(8);
        rd("rise stat", `PMX_IDX_INT_STAT, 32'h0001);
        chk("irq on", irq, 1);
        apb(1'b1, ba(`PMX_IDX_INT_STAT), 32'h0001);
        wt(2);
        chk("irq clr", irq, 0);
        board.pa_ext <= 8'h00;
        wt(8);
        rd("fall stat", `PMX_IDX_INT_STAT, 32'h0002);
        apb(1'b1, ba(`PMX_IDX_INT_STAT), 32'h0002);
        board.pc_ext <= 8'h01;
        wt(8);
        rd("pc rise", `PMX_IDX_INT_STAT, 32'h0100);
        apb(1'b1, ba(`PMX_IDX_INT_STAT), 32'h0100);
        board.pc_ext <= 8'h00;
        wt(8);
        rd("pc fall", `PMX_IDX_INT_STAT, 32'h0100);
        apb(1'b1, ba(`PMX_IDX_INT_MASK), 32'h0000);
        wt(3);
        chk("irq masked", irq, 0);
        apb(1'b0, 16'h0000, 32'h0);
        chk("unmapped err", rerr, 1);
        apb(1'b0, 16'h3f41, 32'h0);
        chk("misaligned err", rerr, 1);
        end_sim();
    end

    initial begin
        wt(20000);
        failures++;
        end_sim();
    end
endmodule
